// ===== hw/angle_sensor_serial_command_port.sv
// three-wire serial command port of the angle sensor, sampled on the system clock
// Behaviour
// RULE1 - master sends 8-bit command byte first
// RULE2 - read: master releases line, device drives after turnaround
// RULE3 - master drives select, clock and write data
// RULE4 - normal mode: one clock per bit, 16 bits
// RULE5 - config command sets reset, hysteresis, offsets, turn bits
// RULE6 - load command presets 9-bit turn counter
// RULE7 - only the fixed key unlocks extended access
// RULE8 - turn read returns counter, error flag, parity
// RULE9 - angle read returns angle, lock, gain, parity
// RULE10 - general reset bit resets device until cleared; the code clears only the turn counter and the unlock flag
// RULE11 - dynamic offset adds 0 to 63 degrees
// RULE12 - angle resolves 360 steps per turn
// RULE13 - angle valid only with lock flag set
// RULE14 - parity is odd over fifteen data bits
// RULE15 - extended mode uses four clocks per bit
// RULE16 - extended write stores image, burn command burns it
// RULE17 - extended read returns image, analog command starts readback
// RULE18 - image layout: test, gain, clock, offsets, poles, zero
// RULE19 - zero value added to angle, range 0..359
// RULE20 - pole code gives 1..6 pairs, top bit inverts
// RULE21 - static offset codes give 0, 2, 4, 8 degrees
// RULE22 - external clock bit forces commutation mode
// RULE23 - select release abandons frame, next starts fresh
`timescale 1ns/1ns
module angle_sensor_serial_command_port (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        select_n_in,
  input  wire logic        serial_clk_in,
  input  wire logic        serial_data_io_in,
  input  wire logic        extended_mode_in,
  input  wire logic        output_mode_select_pin_in,
  input  wire logic [8:0]  angle_raw_in,
  input  wire logic        adc_lock_in,
  input  wire logic [4:0]  gain_control_value_in,
  input  wire logic        programming_error_flag_in,
  output logic             serial_data_io_out,
  output logic             serial_data_io_oe_out,
  output logic             general_reset_bit_out,
  output logic             hysteresis_disable_out,
  output logic [1:0]       turn_control_bits_out,
  output logic [6:0]       commutation_offset_out,
  output logic [8:0]       multiturn_count_out,
  output logic             image_unlocked_out,
  output logic [63:0]      config_image_out,
  output logic             image_burn_out,
  output logic             analog_readback_cmd_out,
  output logic [8:0]       angle_out,
  output logic [2:0]       pole_pairs_out,
  output logic             step_invert_out,
  output logic             ext_pwm_clock_en_out,
  output logic             commutation_mode_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    sensor_port_pkg::state_e st;
    sensor_port_pkg::kind_e  kind;
    logic                    sclk_prev;
    logic [7:0]              cmd;
    logic [63:0]             sh_in;
    logic [63:0]             sh_out;
    logic [6:0]              bits;
    logic [1:0]              sub;
    logic                    adv;
    logic                    oe;
    logic                    ext_frame;
    logic                    general_reset_bit;
    logic                    hyst_dis;
    logic [5:0]              dyn;
    logic [1:0]              turn_ctl;
    logic [8:0]              mt;
    logic                    unlocked;
    logic [63:0]             image;
    logic                    burned;
    logic                    burn_p;
    logic                    ana_p;
    logic [8:0]              angle_o;
    logic [6:0]              comm_off;
    logic [2:0]              pole_pairs;
    logic                    step_inv;
    logic                    ext_clk;
    logic                    comm_mode;
  } state_s;

  state_s q;
  state_s d;

  logic [4:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic       din_s;
  logic       ext_s;
  logic       mode_s;
  logic       rise;
  logic       fall;

  // select and mode pin reset to their idle high: no false frame, no commutation glitch after reset
  bit_sync #(.WIDTH(5), .RESET_VALUE(5'h11)) u_sync (
    .clk_in   (sys_clk_in),
    .rst_in   (rst_in),
    .async_in ({output_mode_select_pin_in, extended_mode_in, serial_data_io_in, serial_clk_in, select_n_in}),
    .sync_out (pins_s)
  );

  assign cs_s   = pins_s[0];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[2];
  assign ext_s  = pins_s[3];
  assign mode_s = pins_s[4];
  assign rise   = sclk_s & ~q.sclk_prev;
  assign fall   = ~sclk_s & q.sclk_prev;

  // ==========================================================================
  // decoding helpers
  function automatic sensor_port_pkg::kind_e decode(input logic [7:0] c, input logic ext, input logic unl);
    sensor_port_pkg::kind_e k;
    k = sensor_port_pkg::K_NONE;
    if (!ext) begin
      case (c)
        sensor_port_pkg::CMD_WRITE_CONFIG: k = sensor_port_pkg::K_CFG;
        sensor_port_pkg::CMD_TURN_LOAD:    k = sensor_port_pkg::K_TURN_SET;
        sensor_port_pkg::CMD_UNLOCK:       k = sensor_port_pkg::K_KEY;
        sensor_port_pkg::CMD_TURN_READ:    k = sensor_port_pkg::K_TURN_RD;
        sensor_port_pkg::CMD_ANGLE_READ:   k = sensor_port_pkg::K_ANGLE_RD;
        default:                           k = sensor_port_pkg::K_NONE;
      endcase
    end else if (unl) begin
      case (c)
        sensor_port_pkg::CMD_IMAGE_WRITE:  k = sensor_port_pkg::K_IMG_WR;
        sensor_port_pkg::CMD_IMAGE_BURN:   k = sensor_port_pkg::K_IMG_BURN;
        sensor_port_pkg::CMD_IMAGE_READ:   k = sensor_port_pkg::K_IMG_RD;
        sensor_port_pkg::CMD_ANALOG_READ:  k = sensor_port_pkg::K_ANALOG;
        default:                           k = sensor_port_pkg::K_NONE;
      endcase
    end
    return k;
  endfunction : decode

  function automatic logic is_read(input sensor_port_pkg::kind_e k);
    return k == sensor_port_pkg::K_TURN_RD || k == sensor_port_pkg::K_ANGLE_RD || k == sensor_port_pkg::K_IMG_RD;
  endfunction : is_read

  function automatic logic [15:0] frame16(input logic [14:0] data);
    return {data, ~^data}; // RULE14
  endfunction : frame16

  function automatic logic [2:0] pole_pairs(input logic [2:0] code);
    return (code <= sensor_port_pkg::MAX_POLE_CODE) ? code + 3'h1 : sensor_port_pkg::MAX_POLE_PAIRS; // RULE20
  endfunction : pole_pairs

  function automatic logic [3:0] static_deg(input logic [1:0] code);
    logic [3:0] r;
    case (code)
      2'h0:    r = 4'h0;
      2'h1:    r = 4'h2;
      2'h2:    r = 4'h4;
      default: r = 4'h8;
    endcase
    return r; // RULE21
  endfunction : static_deg

  // ==========================================================================
  // next state
  logic [9:0]  sum;
  logic [63:0] w;
  logic        bit_done;
  logic [6:0]  len;
  logic [6:0]  bits_n;

  always_comb begin
    d         = q;
    d.burn_p  = 1'b0;
    d.ana_p   = 1'b0;
    d.sclk_prev = sclk_s;
    w         = {q.sh_in[62:0], din_s};
    bit_done  = !q.ext_frame || q.sub == sensor_port_pkg::EXT_LAST_CLOCK; // RULE4 RULE15
    len       = q.ext_frame ? sensor_port_pkg::EXTENDED_BITS : sensor_port_pkg::NORMAL_BITS;
    bits_n    = q.bits + 7'h1;

    // zero offset wraps once or twice, valid zero values keep it to one turn
    sum = {1'b0, angle_raw_in} + {1'b0, q.image[sensor_port_pkg::IMG_ZERO_HI:0]}; // RULE19
    if (sum >= sensor_port_pkg::TWO_TURNS) begin
      sum = sum - sensor_port_pkg::TWO_TURNS;
    end else if (sum >= sensor_port_pkg::STEPS_PER_TURN) begin
      sum = sum - sensor_port_pkg::STEPS_PER_TURN; // RULE12
    end
    d.angle_o    = sum[8:0];
    d.pole_pairs = pole_pairs(q.image[sensor_port_pkg::IMG_POLE_HI:sensor_port_pkg::IMG_POLE_LO]); // RULE18
    d.step_inv   = q.image[sensor_port_pkg::IMG_POLE_HI]; // RULE20
    d.comm_off   = {1'b0, q.dyn}
                 + {3'h0, static_deg(q.image[sensor_port_pkg::IMG_STAT_HI:sensor_port_pkg::IMG_STAT_LO])}; // RULE11
    d.ext_clk    = q.image[sensor_port_pkg::IMG_EXT_CLK];
    d.comm_mode  = q.image[sensor_port_pkg::IMG_EXT_CLK] | ~mode_s; // RULE22

    if (cs_s) begin
      d.st   = sensor_port_pkg::ST_IDLE; // RULE23
      d.oe   = 1'b0;
      d.adv  = 1'b0;
      d.bits = 7'h0;
      d.sub  = 2'h0;
    end else begin
      case (q.st)
        sensor_port_pkg::ST_IDLE: begin
          d.st  = sensor_port_pkg::ST_CMD;
          d.cmd = 8'h00;
        end
        sensor_port_pkg::ST_CMD: begin
          if (rise) begin
            d.cmd  = {q.cmd[6:0], din_s}; // RULE1
            d.bits = bits_n;
            if (q.bits[2:0] == sensor_port_pkg::CMD_LAST_BIT) begin
              d.kind      = decode({q.cmd[6:0], din_s}, ext_s, q.unlocked);
              d.ext_frame = ext_s;
              d.bits      = 7'h0;
              d.sub       = 2'h0;
              d.sh_in     = 64'h0;
              case (d.kind)
                sensor_port_pkg::K_ANGLE_RD: begin
                  d.sh_out = {frame16({q.angle_o, adc_lock_in, gain_control_value_in}), 48'h0}; // RULE9 RULE13
                  d.st     = sensor_port_pkg::ST_RD;
                end
                sensor_port_pkg::K_TURN_RD: begin
                  d.sh_out = {frame16({q.mt, programming_error_flag_in, 5'h00}), 48'h0}; // RULE8
                  d.st     = sensor_port_pkg::ST_RD;
                end
                sensor_port_pkg::K_IMG_RD: begin
                  d.sh_out = q.image; // RULE17
                  d.st     = sensor_port_pkg::ST_RD;
                end
                sensor_port_pkg::K_ANALOG: begin
                  d.ana_p = 1'b1; // RULE17
                  d.st    = sensor_port_pkg::ST_SKIP;
                end
                sensor_port_pkg::K_NONE: d.st = sensor_port_pkg::ST_SKIP;
                default:                 d.st = sensor_port_pkg::ST_WR; // RULE3
              endcase
            end
          end
        end
        sensor_port_pkg::ST_WR: begin
          if (rise) begin
            if (!q.ext_frame || q.sub == 2'h0) begin
              d.sh_in = w;
            end
            d.sub = q.ext_frame ? q.sub + 2'h1 : 2'h0; // RULE15
            if (bit_done) begin
              d.bits = bits_n;
              if (bits_n == len) begin
                d.st = sensor_port_pkg::ST_SKIP;
                case (q.kind)
                  sensor_port_pkg::K_CFG: begin
                    d.general_reset_bit  = d.sh_in[sensor_port_pkg::CFG_GENERAL_RESET_BIT]; // RULE5
                    d.hyst_dis = d.sh_in[sensor_port_pkg::CFG_HYST_DIS];
                    d.dyn      = d.sh_in[sensor_port_pkg::CFG_DYN_HI:sensor_port_pkg::CFG_DYN_LO];
                    d.turn_ctl = {d.sh_in[sensor_port_pkg::CFG_TURN_TWO], d.sh_in[sensor_port_pkg::CFG_TURN_ONE]};
                  end
                  sensor_port_pkg::K_TURN_SET: d.mt = d.sh_in[sensor_port_pkg::TURN_HI:sensor_port_pkg::TURN_LO]; // RULE6
                  sensor_port_pkg::K_KEY: begin
                    if (d.sh_in[15:0] == sensor_port_pkg::UNLOCK_KEY) begin
                      d.unlocked = 1'b1; // RULE7
                    end
                  end
                  sensor_port_pkg::K_IMG_WR: d.image = d.sh_in; // RULE16
                  sensor_port_pkg::K_IMG_BURN: begin
                    d.image  = d.sh_in; // RULE16
                    d.burned = 1'b1;
                    d.burn_p = 1'b1;
                  end
                  default: d.st = sensor_port_pkg::ST_SKIP;
                endcase
              end
            end
          end
        end
        sensor_port_pkg::ST_RD: begin
          if (rise) begin
            d.sub = q.ext_frame ? q.sub + 2'h1 : 2'h0;
            if (bit_done) begin
              d.adv  = 1'b1;
              d.bits = bits_n;
              if (bits_n == len) begin
                d.st  = sensor_port_pkg::ST_SKIP;
                d.adv = 1'b0;
              end
            end
          end else if (fall) begin
            // the line stays released until the first falling edge after the command
            if (!q.oe) begin
              d.oe = 1'b1; // RULE2
            end else if (q.adv) begin
              d.sh_out = {q.sh_out[62:0], 1'b0};
              d.adv    = 1'b0;
            end
          end
        end
        sensor_port_pkg::ST_SKIP: d.st = sensor_port_pkg::ST_SKIP;
        default:                  d.st = sensor_port_pkg::ST_IDLE;
      endcase
    end

    // held while the bit stays set; software has to write it back to zero
    if (q.general_reset_bit) begin
      d.mt       = 9'h000; // RULE10
      d.unlocked = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q           <= '0;
      q.st        <= sensor_port_pkg::ST_IDLE;
      q.kind      <= sensor_port_pkg::K_NONE;
      q.sclk_prev <= 1'b0;
      q.image     <= sensor_port_pkg::IMAGE_RESET;
      q.pole_pairs <= 3'h1;
      q.comm_mode <= 1'b0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign serial_data_io_out      = q.sh_out[63];
  assign serial_data_io_oe_out   = q.oe;
  assign general_reset_bit_out   = q.general_reset_bit;
  assign hysteresis_disable_out  = q.hyst_dis;
  assign turn_control_bits_out   = q.turn_ctl;
  assign commutation_offset_out  = q.comm_off;
  assign multiturn_count_out     = q.mt;
  assign image_unlocked_out      = q.unlocked;
  assign config_image_out        = q.image;
  assign image_burn_out          = q.burn_p;
  assign analog_readback_cmd_out = q.ana_p;
  assign angle_out               = q.angle_o;
  assign pole_pairs_out          = q.pole_pairs;
  assign step_invert_out         = q.step_inv;
  assign ext_pwm_clock_en_out    = q.ext_clk;
  assign commutation_mode_out    = q.comm_mode;

  // ==========================================================================
  // checks
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_cmd_done;
    rise && !cs_s && q.st == sensor_port_pkg::ST_CMD && q.bits[2:0] == sensor_port_pkg::CMD_LAST_BIT;
  endsequence

  sequence s_released;
    !q.oe ##1 !q.oe;
  endsequence

  a_select_abort: assert property ($rose(cs_s) |=> q.st == sensor_port_pkg::ST_IDLE && !q.oe) // RULE23
    else $error("frame not abandoned on select release");
  a_turnaround_float: assert property (s_cmd_done |-> s_released) // RULE2
    else $error("line driven without turnaround");
  a_drive_read_only: assert property (q.oe |-> is_read(q.kind)) // RULE2
    else $error("line driven on a write frame");
  a_parity_odd: assert property (q.st == sensor_port_pkg::ST_RD && !q.oe && q.kind != sensor_port_pkg::K_IMG_RD
                                 |-> ^q.sh_out[63:48]) // RULE14
    else $error("response parity not odd");
  a_key_unlock: assert property ($rose(q.unlocked) |-> q.sh_in[15:0] == sensor_port_pkg::UNLOCK_KEY
                                 && $past(q.kind) == sensor_port_pkg::K_KEY) // RULE7
    else $error("unlocked without key");
  a_turn_load: assert property (q.mt != $past(q.mt) && !$past(q.general_reset_bit)
                                |-> q.mt == q.sh_in[sensor_port_pkg::TURN_HI:sensor_port_pkg::TURN_LO]) // RULE6
    else $error("turn count changed without load");
  a_gen_reset: assert property (q.general_reset_bit |=> q.mt == 9'h000 && !q.unlocked) // RULE10
    else $error("general reset did not clear state");
  a_angle_range: assert property (q.angle_o < sensor_port_pkg::STEPS_PER_TURN[8:0]
                                  || $past(angle_raw_in) >= sensor_port_pkg::STEPS_PER_TURN[8:0]) // RULE19
    else $error("angle outside one turn");
  a_four_clocks: assert property (q.sub != 2'h0 |-> q.ext_frame) // RULE15
    else $error("sub-bit clock count in normal frame");
  a_pole_range: assert property (q.pole_pairs >= 3'h1 && q.pole_pairs <= sensor_port_pkg::MAX_POLE_PAIRS) // RULE20
    else $error("pole pair count out of range");

endmodule : angle_sensor_serial_command_port

// ===== hw/sensor_port_pkg.sv
// constants and types shared by the angle sensor serial command port
package sensor_port_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_WRITE_CONFIG = 8'h17;
  localparam logic [7:0] CMD_TURN_LOAD    = 8'h14;
  localparam logic [7:0] CMD_UNLOCK       = 8'h84;
  localparam logic [7:0] CMD_TURN_READ    = 8'h04;
  localparam logic [7:0] CMD_ANGLE_READ   = 8'h00;
  localparam logic [7:0] CMD_IMAGE_WRITE  = 8'h1f;
  localparam logic [7:0] CMD_IMAGE_BURN   = 8'h19;
  localparam logic [7:0] CMD_IMAGE_READ   = 8'h0f;
  localparam logic [7:0] CMD_ANALOG_READ  = 8'h09;

  localparam logic [15:0] UNLOCK_KEY = 16'h6570;

  // ==========================================================================
  // frame lengths and counters
  localparam logic [2:0] CMD_LAST_BIT   = 3'h7;
  localparam logic [6:0] NORMAL_BITS    = 7'h10;
  localparam logic [6:0] EXTENDED_BITS  = 7'h40;
  localparam logic [1:0] EXT_LAST_CLOCK = 2'h3;

  // ==========================================================================
  // configuration word fields
  localparam int CFG_GENERAL_RESET_BIT  = 14;
  localparam int CFG_HYST_DIS = 13;
  localparam int CFG_DYN_HI   = 12;
  localparam int CFG_DYN_LO   = 7;
  localparam int CFG_TURN_TWO = 6;
  localparam int CFG_TURN_ONE = 5;
  localparam int TURN_HI      = 15;
  localparam int TURN_LO      = 7;

  // ==========================================================================
  // programmable image fields
  localparam int IMG_ZERO_HI   = 8;
  localparam int IMG_POLE_HI   = 11;
  localparam int IMG_POLE_LO   = 9;
  localparam int IMG_STAT_HI   = 13;
  localparam int IMG_STAT_LO   = 12;
  localparam int IMG_EXT_CLK   = 14;
  localparam logic [63:0] IMAGE_RESET = 64'h0;

  // ==========================================================================
  // angle arithmetic
  localparam logic [9:0] STEPS_PER_TURN = 10'h168;
  localparam logic [9:0] TWO_TURNS      = 10'h2d0;
  localparam logic [2:0] MAX_POLE_CODE  = 3'h4;
  localparam logic [2:0] MAX_POLE_PAIRS = 3'h6;

  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_WR, ST_RD, ST_SKIP} state_e;

  typedef enum logic [3:0] {
    K_NONE, K_CFG, K_TURN_SET, K_KEY, K_TURN_RD, K_ANGLE_RD,
    K_IMG_WR, K_IMG_BURN, K_IMG_RD, K_ANALOG
  } kind_e;

endpackage : sensor_port_pkg

// ===== hw/bit_sync.sv
// two flip-flop synchroniser for a group of unrelated pin levels
`timescale 1ns/1ns
module bit_sync #(
  parameter int            WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // the first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q   <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : bit_sync

// ===== testbench/serial_master_model.sv
// microcontroller model that masters the three-wire serial command port
`timescale 1ns/1ns
module serial_master_model (
  input  wire logic sys_clk_in,
  input  wire logic line_in,
  output logic      select_n_out,
  output logic      serial_clk_out,
  output logic      data_out,
  output logic      data_oe_out
);
  // serial clock rests low between frames
  initial begin
    select_n_out = 1'b1;
    serial_clk_out = 1'b0;
    data_out = 1'b1;
    data_oe_out = 1'b0;
  end

  // ==========================================================================
  // one serial clock of 320 ns, line sampled late in the high phase
  task automatic pulse(output logic seen);
    repeat (4) @(posedge sys_clk_in);
    serial_clk_out <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    seen = line_in;
    serial_clk_out <= 1'b0;
  endtask : pulse

  // ==========================================================================
  // whole frame: command byte, then nbits data bits of cpb clocks each
  task automatic frame(input logic [7:0] cmd, input logic [63:0] wr, input int nbits,
                       input logic rd, input int cpb, output logic [63:0] rdv);
    logic s;
    rdv = '0;
    select_n_out <= 1'b0;
    data_oe_out <= 1'b1;
    for (int i = 7; i >= 0; i--) begin
      data_out <= cmd[i];
      pulse(s);
    end
    if (rd) data_oe_out <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      data_out <= wr[i];
      for (int k = 0; k < cpb; k++) begin
        pulse(s);
        if (k == 0) rdv[i] = s;
      end
    end
    repeat (4) @(posedge sys_clk_in);
    select_n_out <= 1'b1;
    data_oe_out <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
  endtask : frame
endmodule : serial_master_model

// ===== testbench/angle_sensor_serial_command_port_tb.sv
// self-checking bench of the angle sensor serial command port
`timescale 1ns/1ns
module angle_sensor_serial_command_port_tb;
  logic        sys_clk_in, rst_in, ext, pin, lock, err;
  logic [8:0]  raw, count, angle;
  logic [4:0]  gain;
  logic        serial_data_io, dio_oe, general_reset_bit, hyst, unlocked, burn, ana, step_inv, ext_clk, com_mode;
  logic [1:0]  turn_bits;
  logic [6:0]  offset;
  logic [2:0]  pairs;
  logic [63:0] image, r;
  logic        sel_n, sclk, m_data, m_oe;
  wire         line = dio_oe ? serial_data_io : (m_oe ? m_data : 1'b1); // pull-up on released line
  int          n_mismatch = 0, check_count = 0, n_burn = 0, n_ana = 0;

  angle_sensor_serial_command_port dut (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .select_n_in(sel_n), .serial_clk_in(sclk),
    .serial_data_io_in(line), .extended_mode_in(ext), .output_mode_select_pin_in(pin),
    .angle_raw_in(raw), .adc_lock_in(lock), .gain_control_value_in(gain),
    .programming_error_flag_in(err), .serial_data_io_out(serial_data_io), .serial_data_io_oe_out(dio_oe),
    .general_reset_bit_out(general_reset_bit), .hysteresis_disable_out(hyst), .turn_control_bits_out(turn_bits),
    .commutation_offset_out(offset), .multiturn_count_out(count), .image_unlocked_out(unlocked),
    .config_image_out(image), .image_burn_out(burn), .analog_readback_cmd_out(ana),
    .angle_out(angle), .pole_pairs_out(pairs), .step_invert_out(step_inv),
    .ext_pwm_clock_en_out(ext_clk), .commutation_mode_out(com_mode));

  serial_master_model m (.sys_clk_in(sys_clk_in), .line_in(line), .select_n_out(sel_n),
    .serial_clk_out(sclk), .data_out(m_data), .data_oe_out(m_oe));

  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (burn === 1'b1) n_burn <= n_burn + 1;
    if (ana === 1'b1) n_ana <= n_ana + 1;
  end

  // ==========================================================================
  // shared helpers
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic wr16(input logic [7:0] cmd, input logic [15:0] d);
    m.frame(cmd, {48'h0, d}, 16, 1'b0, 1, r);
  endtask : wr16

  task automatic wr64(input logic [7:0] cmd, input logic [63:0] d);
    m.frame(cmd, d, 64, 1'b0, 4, r);
  endtask : wr64

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim

  // ==========================================================================
  // scenarios
  task automatic t_turn();
    logic [15:0] e;
    chk(pairs, 3'h1, "pairs after reset");
    chk(image, sensor_port_pkg::IMAGE_RESET, "image after reset");
    wr16(sensor_port_pkg::CMD_TURN_LOAD, {9'h1a5, 7'h0});
    chk(count, 9'h1a5, "turn load");
    @(posedge sys_clk_in) err <= 1'b1;
    m.frame(sensor_port_pkg::CMD_TURN_READ, 64'h0, 16, 1'b1, 1, r);
    e = {9'h1a5, 1'b1, 6'h0};
    e[0] = ~^e[15:1];
    chk(r[15:0], e, "turn read frame");
    chk(dio_oe, 1'b0, "line released");
  endtask : t_turn

  // 359 without lock is the top boundary; the lock bit must follow the input
  task automatic t_angle();
    logic [15:0] e;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk_in);
      raw <= i ? 9'd359 : 9'd300;
      lock <= ~i[0];
      gain <= i ? 5'h0a : 5'h15;
      m.frame(sensor_port_pkg::CMD_ANGLE_READ, 64'h0, 16, 1'b1, 1, r);
      e = {raw, lock, gain, 1'b0};
      e[0] = ~^e[15:1];
      chk(r[15:0], e, "angle frame");
    end
  endtask : t_angle

  task automatic t_config();
    wr16(sensor_port_pkg::CMD_WRITE_CONFIG, 16'h3fc0);
    chk({general_reset_bit, hyst, turn_bits}, 4'h6, "config bits");
    chk(offset, 7'd63, "dynamic offset");
    m.frame(sensor_port_pkg::CMD_TURN_LOAD, 64'hffff, 12, 1'b0, 1, r);
    chk(count, 9'h1a5, "aborted load");
  endtask : t_config

  task automatic t_unlock();
    wr16(sensor_port_pkg::CMD_UNLOCK, 16'h6571);
    chk(unlocked, 1'b0, "wrong key");
    wr16(sensor_port_pkg::CMD_UNLOCK, sensor_port_pkg::UNLOCK_KEY);
    chk(unlocked, 1'b1, "key");
    wr16(sensor_port_pkg::CMD_WRITE_CONFIG, 16'h7fc0);
    chk({general_reset_bit, unlocked, count}, {2'b10, 9'h0}, "general reset");
    wr16(sensor_port_pkg::CMD_WRITE_CONFIG, 16'h3fc0);
    chk(general_reset_bit, 1'b0, "general reset cleared");
    @(posedge sys_clk_in) ext <= 1'b1;
    wr64(sensor_port_pkg::CMD_IMAGE_WRITE, '1);
    chk(image, 64'h0, "locked image write");
  endtask : t_unlock

  task automatic t_image();
    logic [63:0] img;
    @(posedge sys_clk_in) ext <= 1'b0;
    wr16(sensor_port_pkg::CMD_UNLOCK, sensor_port_pkg::UNLOCK_KEY);
    @(posedge sys_clk_in) ext <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      img = {50'h0, i[1:0], i[2:0], 9'd350};
      wr64(sensor_port_pkg::CMD_IMAGE_WRITE, img);
      chk(image, img, "image write");
      chk(pairs, (i > 4) ? 6 : i + 1, "pole pairs");
      chk(step_inv, i[2], "step invert");
      chk(offset, 63 + ((i % 4 == 3) ? 8 : 2 * (i % 4)), "offset sum");
    end
    chk(angle, 9'd349, "zero added");
    chk(com_mode, 1'b0, "incremental");
    @(posedge sys_clk_in) pin <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    chk(com_mode, 1'b1, "pin commutation");
    @(posedge sys_clk_in) pin <= 1'b1;
    img = 64'ha5c3_0f00_0001_c00a;
    wr64(sensor_port_pkg::CMD_IMAGE_WRITE, img);
    chk({ext_clk, com_mode}, 2'b11, "external clock");
    m.frame(sensor_port_pkg::CMD_IMAGE_READ, 64'h0, 64, 1'b1, 4, r);
    chk(r, img, "image read");
    wr64(sensor_port_pkg::CMD_IMAGE_BURN, img);
    chk(n_burn, 1, "burn pulse");
    m.frame(sensor_port_pkg::CMD_ANALOG_READ, 64'h0, 0, 1'b1, 4, r);
    chk(n_ana, 1, "analog pulse");
  endtask : t_image

  initial begin
    #3_000_000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    rst_in = 1'b1;
    {ext, lock, err, gain} = '0;
    pin = 1'b1;
    raw = 9'd100;
    repeat (4) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    chk(com_mode, 1'b0, "mode after reset");
    repeat (2) @(posedge sys_clk_in);
    t_turn();
    t_angle();
    t_config();
    t_unlock();
    t_image();
    end_sim();
  end
endmodule : angle_sensor_serial_command_port_tb
